// ===== pkg/pdos_defs.vh
// Register offsets, field layouts, reset values and serial constants.
`ifndef PDOS_DEFS_VH
`define PDOS_DEFS_VH

// Serial slave address (7 bits).
`define PDOS_SLAVE_ADDR      7'h69

// Register offsets.
`define PDOS_OFS_OE          8'h09
`define PDOS_OFS_BANK1       8'h0c
`define PDOS_OFS_TRIM        8'h13
`define PDOS_OFS_PLL0        8'h40
`define PDOS_OFS_PLL1        8'h41
`define PDOS_OFS_PLL2        8'h42
`define PDOS_OFS_XP0         8'h44
`define PDOS_OFS_XP1         8'h45
`define PDOS_OFS_XP2         8'h46
`define PDOS_OFS_BANK2       8'h47

// Writable bits and fixed bits per register.
`define PDOS_OE_WMASK        8'h34
`define PDOS_PLL0_WMASK      8'h1f
`define PDOS_PLL0_FIXED      8'hc0
`define PDOS_XP0_WMASK       8'h03
`define PDOS_XP0_FIXED       8'hfc
`define PDOS_XP1_WMASK       8'h8f
`define PDOS_XP1_FIXED       8'h70
`define PDOS_XP2_WMASK       8'hc0
`define PDOS_XP2_FIXED       8'h3f

// Field positions.
`define PDOS_OE_BIT_C        5
`define PDOS_OE_BIT_A        4
`define PDOS_OE_BIT_B        2
`define PDOS_SRC_SEL_BIT     7

// Fixed offsets of the frequency formulas.
`define PDOS_MULT_BASE_ADD   12'h008
`define PDOS_REF_DIV_ADD     8'h02

// Reset values.
`define PDOS_RST_OE          8'h34
`define PDOS_RST_BANK1       8'h08
`define PDOS_RST_TRIM        8'h00
`define PDOS_RST_PLL0        8'hc0
`define PDOS_RST_PLL1        8'h10
`define PDOS_RST_PLL2        8'h00
`define PDOS_RST_XP0         8'hfc
`define PDOS_RST_XP1         8'hf2
`define PDOS_RST_XP2         8'h7f
`define PDOS_RST_BANK2       8'h08

`endif

// ===== verilog/pdos_bank_div.v
// One post-divider bank: variable divisor plus fixed /2 and /3-or-/4 taps.
`default_nettype none

module pdos_bank_div #(
  parameter [2:0] FIXED_MOD = 3'h3
) (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       tick,
  input  wire [6:0] divisor,
  output reg        divN_r,
  output reg        div2_r,
  output reg        divM_r
);

  localparam [1:0] LAST = FIXED_MOD[1:0] - 2'h1;
  localparam [1:0] HALF = FIXED_MOD[2:1];

  reg  [6:0] cnt_r;
  reg        c2_r;
  reg  [1:0] cm_r;
  wire [6:0] cntInc;
  wire [6:0] cntNxt;
  wire       wrap;
  wire       c2Nxt;
  wire [1:0] cmNxt;

  assign cntInc = cnt_r + 7'h01;
  // A divisor of zero parks the counter, so the tap stays static.
  assign cntNxt = (cntInc >= divisor) ? 7'h00 : cntInc;
  assign wrap   = (cntNxt == 7'h00);
  // Fixed taps restart on every wrap of the variable counter, so their
  // rising edges coincide with it whenever the divisor is a multiple.
  assign c2Nxt  = wrap ? 1'b0 : ~c2_r;
  assign cmNxt  = (wrap || cm_r == LAST) ? 2'h0 : cm_r + 2'h1;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r  <= 7'h00;
      c2_r   <= 1'b0;
      cm_r   <= 2'h0;
      divN_r <= 1'b0;
      div2_r <= 1'b0;
      divM_r <= 1'b0;
    end else if (tick) begin
      cnt_r  <= cntNxt;
      c2_r   <= c2Nxt;
      cm_r   <= cmNxt;
      divN_r <= (cntNxt < {1'b0, divisor[6:1]});
      div2_r <= ~c2Nxt;
      divM_r <= (cmNxt < HALF);
    end
  end

endmodule // pdos_bank_div

`default_nettype wire

// ===== verilog/pdos_top.v
// Clock synthesizer configuration: serial slave, registers, crosspoint.
`default_nettype none
`include "pdos_defs.vh"
// Functional notes
// - VCO is reference over predivider times multiplier.
// - Multiplier equals two times base plus eight, plus odd.
// - Base field spans 40H bits 1..0 and 41H.
// - 42H holds odd bit and predivider field.
// - 40H upper three bits stay fixed at 110.
// - Bank bit 7 picks VCO or reference input.
// - Bank divisor is seven bits, kept 4 to 127; the register file stores any value 0 to 127 unchecked.
// - Banks also offer fixed /2, /3, /4 taps.
// - Codes 000-011: reference, bank1 /N, /2, /3.
// - Codes 100-110: bank2 /N, /2, /4; 111 reserved.
// - Output source codes placed across 44H, 45H, 46H.
// - Bank1 /2 and /3 align with /N edges.
// - Bank2 /2 and /4 align with /N edges.
// - 09H enables outputs C, A, B; others zero.
// - Predivider total is field plus two.

module pdos_top (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        sclIn,
  input  wire        sdaIn,
  output reg         sdaOut_r,
  output reg         sdaOe_r,
  input  wire        vcoIn,
  output reg         outputA_r,
  output reg         outputB_r,
  output reg         outputC_r,
  output reg  [7:0]  refDivideTotal_r,
  output reg  [11:0] multTotal_r,
  output reg  [2:0]  loopCurrent_r,
  output reg  [7:0]  crystalLoadTrim_r
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_RX    = 3'h1;
  localparam [2:0] ST_ACK   = 3'h2;
  localparam [2:0] ST_TX    = 3'h3;
  localparam [2:0] ST_TXACK = 3'h4;

  // Synchroniser lanes: bit 0 clock line, bit 1 data line, bit 2 VCO.
  reg  [2:0] s1_r;
  reg  [2:0] s2_r;
  reg  [2:0] s3_r;
  reg  [2:0] filt_r;
  reg  [2:0] prev_r;

  reg  [2:0] state_r;
  reg  [3:0] bitCnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] ptr_r;
  reg        isAddr_r;
  reg        ptrNext_r;
  reg        readMode_r;
  reg        nack_r;

  reg  [7:0] regOe_r;
  reg  [7:0] regBank1_r;
  reg  [7:0] regTrim_r;
  reg  [7:0] regPll0_r;
  reg  [7:0] regPll1_r;
  reg  [7:0] regPll2_r;
  reg  [7:0] regXp0_r;
  reg  [7:0] regXp1_r;
  reg  [7:0] regXp2_r;
  reg  [7:0] regBank2_r;
  reg        refTog_r;

  wire       sclRise;
  wire       sclFall;
  wire       startDet;
  wire       stopDet;
  wire       vcoTick;
  wire       wrStb;
  wire [7:0] rdByte;
  wire       tick1;
  wire       tick2;
  wire       b1N;
  wire       b1d2;
  wire       b1d3;
  wire       b2N;
  wire       b2d2;
  wire       b2d4;
  wire [2:0] codeA;
  wire [2:0] codeB;
  wire [2:0] codeC;
  wire [9:0] multBase;

  function [7:0] readReg;
    input [7:0] a;
    begin
      case (a)
        `PDOS_OFS_OE:    readReg = regOe_r;
        `PDOS_OFS_BANK1: readReg = regBank1_r;
        `PDOS_OFS_TRIM:  readReg = regTrim_r;
        `PDOS_OFS_PLL0:  readReg = regPll0_r;
        `PDOS_OFS_PLL1:  readReg = regPll1_r;
        `PDOS_OFS_PLL2:  readReg = regPll2_r;
        `PDOS_OFS_XP0:   readReg = regXp0_r;
        `PDOS_OFS_XP1:   readReg = regXp1_r;
        `PDOS_OFS_XP2:   readReg = regXp2_r;
        `PDOS_OFS_BANK2: readReg = regBank2_r;
        default:         readReg = 8'h00;
      endcase
    end
  endfunction

  function srcLevel;
    input [2:0] code;
    begin
      case (code)
        3'h0:    srcLevel = refTog_r;
        3'h1:    srcLevel = b1N;
        3'h2:    srcLevel = b1d2;
        3'h3:    srcLevel = b1d3;
        3'h4:    srcLevel = b2N;
        3'h5:    srcLevel = b2d2;
        3'h6:    srcLevel = b2d4;
        default: srcLevel = 1'b0;
      endcase
    end
  endfunction

  // Three-stage sampling; a level is accepted only once stages two and
  // three agree, which rejects single-sample glitches on the pins.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r   <= 3'h7;
      s2_r   <= 3'h7;
      s3_r   <= 3'h7;
      filt_r <= 3'h7;
      prev_r <= 3'h7;
    end else begin
      s1_r   <= {vcoIn, sdaIn, sclIn};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
      prev_r <= filt_r;
    end
  end

  assign sclRise  = filt_r[0] & ~prev_r[0];
  assign sclFall  = ~filt_r[0] & prev_r[0];
  assign startDet = prev_r[1] & ~filt_r[1] & filt_r[0] & prev_r[0];
  assign stopDet  = ~prev_r[1] & filt_r[1] & filt_r[0] & prev_r[0];
  assign vcoTick  = filt_r[2] & ~prev_r[2];
  assign rdByte   = readReg(ptr_r);
  assign wrStb    = (state_r == ST_RX) && sclFall && (bitCnt_r == 4'h8) &&
                    !isAddr_r && !ptrNext_r;

  // Serial slave: address byte, register pointer, then auto-incrementing
  // data; a read returns bytes from the pointer until the master NACKs.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= ST_IDLE;
      bitCnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      ptr_r      <= 8'h00;
      isAddr_r   <= 1'b0;
      ptrNext_r  <= 1'b0;
      readMode_r <= 1'b0;
      nack_r     <= 1'b0;
      sdaOe_r    <= 1'b0;
      sdaOut_r   <= 1'b0;
    end else if (stopDet) begin
      state_r <= ST_IDLE;
      sdaOe_r <= 1'b0;
    end else if (startDet) begin
      state_r  <= ST_RX;
      bitCnt_r <= 4'h0;
      isAddr_r <= 1'b1;
      sdaOe_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (sclRise && bitCnt_r != 4'h8) begin
            shift_r  <= {shift_r[6:0], filt_r[1]};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (sclFall && bitCnt_r == 4'h8) begin
            isAddr_r <= 1'b0;
            if (isAddr_r) begin
              if (shift_r[7:1] == `PDOS_SLAVE_ADDR) begin
                readMode_r <= shift_r[0];
                ptrNext_r  <= ~shift_r[0];
                state_r    <= ST_ACK;
                sdaOe_r    <= 1'b1;
              end else begin
                state_r <= ST_IDLE;
              end
            end else begin
              if (ptrNext_r) begin
                ptr_r <= shift_r;
              end else begin
                ptr_r <= ptr_r + 8'h01;
              end
              ptrNext_r <= 1'b0;
              state_r   <= ST_ACK;
              sdaOe_r   <= 1'b1;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            if (readMode_r) begin
              shift_r  <= rdByte;
              sdaOe_r  <= ~rdByte[7];
              ptr_r    <= ptr_r + 8'h01;
              bitCnt_r <= 4'h1;
              state_r  <= ST_TX;
            end else begin
              bitCnt_r <= 4'h0;
              sdaOe_r  <= 1'b0;
              state_r  <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt_r == 4'h8) begin
              sdaOe_r <= 1'b0;
              state_r <= ST_TXACK;
            end else begin
              sdaOe_r  <= ~shift_r[6];
              shift_r  <= {shift_r[6:0], 1'b0};
              bitCnt_r <= bitCnt_r + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (sclRise) begin
            nack_r <= filt_r[1];
          end else if (sclFall) begin
            if (nack_r) begin
              state_r <= ST_IDLE;
            end else begin
              shift_r  <= rdByte;
              sdaOe_r  <= ~rdByte[7];
              ptr_r    <= ptr_r + 8'h01;
              bitCnt_r <= 4'h1;
              state_r  <= ST_TX;
            end
          end
        end
        default: begin
          sdaOe_r <= 1'b0;
        end
      endcase
    end
  end

  // Register file. Fixed bits are forced on every write; writes to any
  // unmapped offset are dropped rather than stored.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regOe_r    <= `PDOS_RST_OE;
      regBank1_r <= `PDOS_RST_BANK1;
      regTrim_r  <= `PDOS_RST_TRIM;
      regPll0_r  <= `PDOS_RST_PLL0;
      regPll1_r  <= `PDOS_RST_PLL1;
      regPll2_r  <= `PDOS_RST_PLL2;
      regXp0_r   <= `PDOS_RST_XP0;
      regXp1_r   <= `PDOS_RST_XP1;
      regXp2_r   <= `PDOS_RST_XP2;
      regBank2_r <= `PDOS_RST_BANK2;
    end else if (wrStb) begin
      case (ptr_r)
        `PDOS_OFS_OE:    regOe_r <= shift_r & `PDOS_OE_WMASK;
        `PDOS_OFS_BANK1: regBank1_r <= shift_r;
        `PDOS_OFS_TRIM:  regTrim_r <= shift_r;
        `PDOS_OFS_PLL0:
          regPll0_r <= (shift_r & `PDOS_PLL0_WMASK) |
                       `PDOS_PLL0_FIXED;
        `PDOS_OFS_PLL1:  regPll1_r <= shift_r;
        `PDOS_OFS_PLL2:  regPll2_r <= shift_r;
        `PDOS_OFS_XP0:
          regXp0_r <= (shift_r & `PDOS_XP0_WMASK) |
                      `PDOS_XP0_FIXED;
        `PDOS_OFS_XP1:
          regXp1_r <= (shift_r & `PDOS_XP1_WMASK) |
                      `PDOS_XP1_FIXED;
        `PDOS_OFS_XP2:
          regXp2_r <= (shift_r & `PDOS_XP2_WMASK) |
                      `PDOS_XP2_FIXED;
        `PDOS_OFS_BANK2: regBank2_r <= shift_r;
        default: ;
      endcase
    end
  end

  // Control words for the analog loop; the oscillator itself lives
  // outside and returns on the VCO pin.
  assign multBase = {regPll0_r[1:0], regPll1_r};

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      multTotal_r       <= 12'h000;
      refDivideTotal_r  <= 8'h00;
      loopCurrent_r     <= 3'h0;
      crystalLoadTrim_r <= 8'h00;
    end else begin
      multTotal_r <= {1'b0, multBase, 1'b0} + `PDOS_MULT_BASE_ADD +
                     {11'h000, regPll2_r[7]};
      refDivideTotal_r <= {1'b0, regPll2_r[6:0]} +
                          `PDOS_REF_DIV_ADD;
      loopCurrent_r     <= regPll0_r[4:2];
      crystalLoadTrim_r <= regTrim_r;
    end
  end

  // The reference is represented by a half-rate toggle, since an output
  // flop cannot reproduce its own clock.
  assign tick1 = regBank1_r[`PDOS_SRC_SEL_BIT] ? vcoTick : 1'b1;
  assign tick2 = regBank2_r[`PDOS_SRC_SEL_BIT] ? vcoTick : 1'b1;

  pdos_bank_div #(
    .FIXED_MOD (3'h3)
  ) u_bank1 (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tick    (tick1),
    .divisor (regBank1_r[6:0]),
    .divN_r  (b1N),
    .div2_r  (b1d2),
    .divM_r  (b1d3)
  );

  pdos_bank_div #(
    .FIXED_MOD (3'h4)
  ) u_bank2 (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tick    (tick2),
    .divisor (regBank2_r[6:0]),
    .divN_r  (b2N),
    .div2_r  (b2d2),
    .divM_r  (b2d4)
  );

  assign codeB = {regXp0_r[1:0], regXp1_r[7]};
  assign codeA = regXp1_r[3:1];
  assign codeC = {regXp1_r[0], regXp2_r[7:6]};

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      refTog_r  <= 1'b0;
      outputA_r <= 1'b0;
      outputB_r <= 1'b0;
      outputC_r <= 1'b0;
    end else begin
      refTog_r  <= ~refTog_r;
      outputA_r <= regOe_r[`PDOS_OE_BIT_A] & srcLevel(codeA);
      outputB_r <= regOe_r[`PDOS_OE_BIT_B] & srcLevel(codeB);
      outputC_r <= regOe_r[`PDOS_OE_BIT_C] & srcLevel(codeC);
    end
  end

endmodule // pdos_top

`default_nettype wire

// ===== bench/pdos_top_asserts.sv
// Port-level assertions for the clock synthesizer configuration block.
`default_nettype none

module pdos_top_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        sclIn,
  input wire logic [7:0]  refDivideTotal_r,
  input wire logic [11:0] multTotal_r,
  input wire logic [2:0]  loopCurrent_r,
  input wire logic [7:0]  crystalLoadTrim_r
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       live_r;
  logic       sclPrev_r;
  logic [3:0] quietCnt_r;

  // Eight quiet cycles on the serial clock cover the pin filter and the
  // register update, so no configuration output may move after that.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      live_r     <= 1'b0;
      sclPrev_r  <= 1'b1;
      quietCnt_r <= 4'h0;
    end else begin
      live_r    <= 1'b1;
      sclPrev_r <= sclIn;
      if (sclIn != sclPrev_r)
        quietCnt_r <= 4'h0;
      else if (quietCnt_r != 4'hf)
        quietCnt_r <= quietCnt_r + 4'h1;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_multFloor;
    live_r |-> multTotal_r >= 12'd8;
  endproperty
  a_multFloor: assert property (p_multFloor)
    else $error("multiplier total below minimum");

  property p_multCeil;
    live_r |-> multTotal_r <= 12'd2055;
  endproperty
  a_multCeil: assert property (p_multCeil)
    else $error("multiplier total above maximum");

  property p_refFloor;
    live_r |-> refDivideTotal_r >= 8'd2;
  endproperty
  a_refFloor: assert property (p_refFloor)
    else $error("predivider total below minimum");

  property p_refCeil;
    live_r |-> refDivideTotal_r <= 8'd129;
  endproperty
  a_refCeil: assert property (p_refCeil)
    else $error("predivider total above maximum");

  property p_multReset;
    $rose(live_r) |-> multTotal_r == 12'h028;
  endproperty
  a_multReset: assert property (p_multReset)
    else $error("multiplier total wrong after reset");

  property p_refReset;
    $rose(live_r) |-> refDivideTotal_r == 8'h02;
  endproperty
  a_refReset: assert property (p_refReset)
    else $error("predivider total wrong after reset");

  property p_pumpReset;
    $rose(live_r) |-> loopCurrent_r == 3'h0 && crystalLoadTrim_r == 8'h00;
  endproperty
  a_pumpReset: assert property (p_pumpReset)
    else $error("loop current or trim wrong after reset");

  property p_quietHold;
    quietCnt_r >= 4'h8 |-> $stable(multTotal_r) && $stable(refDivideTotal_r)
      && $stable(loopCurrent_r) && $stable(crystalLoadTrim_r);
  endproperty
  a_quietHold: assert property (p_quietHold)
    else $error("configuration changed without bus traffic");
endmodule // pdos_top_asserts

bind pdos_top pdos_top_asserts u_asserts (
  .sys_clk          (sys_clk),
  .rst_b            (rst_b),
  .sclIn            (sclIn),
  .refDivideTotal_r (refDivideTotal_r),
  .multTotal_r      (multTotal_r),
  .loopCurrent_r    (loopCurrent_r),
  .crystalLoadTrim_r(crystalLoadTrim_r)
);
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench: serial register access, crosspoint and enables.
`default_nettype none
`include "pdos_defs.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sclIn = 1'b1;
  logic        mSda = 1'b1;
  logic        vcoIn = 1'b0;
  logic [3:0]  vcoCnt = 4'h0;
  wire         sdaOut, sdaOe, outA, outB, outC;
  wire  [7:0]  refDiv, trim;
  wire  [11:0] mult;
  wire  [2:0]  pump;
  wire         sdaWire = mSda & ~sdaOe;
  logic [15:0] riseA, riseB, riseC, co;
  int          n_errors = 0;
  int          cmp_count = 0;
  logic [15:0] rstTab [10] = '{16'h0934, 16'h0c08, 16'h1300, 16'h40c0,
    16'h4110, 16'h4200, 16'h44fc, 16'h45f2, 16'h467f, 16'h4708};
  // Table words keep the loop current matched to the multiplier, keep the
  // low bits of the third crosspoint register at ones, probe the unmapped
  // offset 12H and leave an unused bank at divisor 8.
  logic [23:0] rwTab [12] = '{24'h09ff34, 24'h090000, 24'h093434,
    24'h13a5a5, 24'h402dcd, 24'h417f7f,
    24'h42ffff, 24'h4400fc, 24'h450070,
    24'h467f7f, 24'h478888, 24'h125500};
  logic [15:0] expA [8] = '{16'd48, 16'd8, 16'd48, 16'd32, 16'd6, 16'd48,
    16'd24, 16'd0};

  always #2.5 sys_clk = ~sys_clk;

  // The VCO stand-in ticks once every 16 cycles, well below the pin filter.
  always @(posedge sys_clk) begin
    vcoCnt <= vcoCnt + 4'h1;
    vcoIn  <= vcoCnt[3];
  end

  pdos_top uut (
    .sys_clk          (sys_clk),
    .rst_b            (rst_b),
    .sclIn            (sclIn),
    .sdaIn            (sdaWire),
    .sdaOut_r         (sdaOut),
    .sdaOe_r          (sdaOe),
    .vcoIn            (vcoIn),
    .outputA_r        (outA),
    .outputB_r        (outB),
    .outputC_r        (outC),
    .refDivideTotal_r (refDiv),
    .multTotal_r      (mult),
    .loopCurrent_r    (pump),
    .crystalLoadTrim_r(trim)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic hc();
    repeat (10) @(posedge sys_clk);
  endtask

  // Data moves only while the clock has been low for a while, so the filtered
  // pins never show a data edge during a high clock by accident.
  task automatic sbit(input logic b, output logic r);
    hc();
    mSda <= b;
    hc();
    sclIn <= 1'b1;
    hc();
    r = sdaWire;
    sclIn <= 1'b0;
  endtask

  task automatic sbyte(input logic [7:0] d, output logic [7:0] q,
                       output logic ack);
    for (int i = 7; i >= 0; i--)
      sbit(d[i], q[i]);
    sbit(1'b1, ack);
  endtask

  task automatic sstart();
    hc();
    mSda <= 1'b1;
    hc();
    sclIn <= 1'b1;
    hc();
    mSda <= 1'b0;
    hc();
    sclIn <= 1'b0;
  endtask

  task automatic sstop();
    hc();
    mSda <= 1'b0;
    hc();
    sclIn <= 1'b1;
    hc();
    mSda <= 1'b1;
    hc();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       k;
    sstart();
    sbyte({`PDOS_SLAVE_ADDR, 1'b0}, q, k);
    sbyte(a, q, k);
    sbyte(d, q, k);
    sstop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    sstart();
    sbyte({`PDOS_SLAVE_ADDR, 1'b0}, d, k);
    sbyte(a, d, k);
    sstart();
    sbyte({`PDOS_SLAVE_ADDR, 1'b1}, d, k);
    sbyte(8'hff, d, k);
    sstop();
  endtask

  task automatic measure(input int n);
    logic pa, pb, pc;
    @(posedge sys_clk);
    #1;
    {riseA, riseB, riseC, co} = '0;
    {pa, pb, pc} = {outA, outB, outC};
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      riseA = riseA + 16'(outA && !pa);
      riseB = riseB + 16'(outB && !pb);
      riseC = riseC + 16'(outC && !pc);
      co = co + 16'(outA && !pa && outB && !pb);
      {pa, pb, pc} = {outA, outB, outC};
    end
  endtask

  initial begin
    logic [7:0] d;
    logic [2:0] code;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    foreach (rstTab[i]) begin
      rd(rstTab[i][15:8], d);
      check(16'(d), 16'(rstTab[i][7:0]));
    end
    foreach (rwTab[i]) begin
      wr(rwTab[i][23:16], rwTab[i][15:8]);
      rd(rwTab[i][23:16], d);
      check(16'(d), 16'(rwTab[i][7:0]));
    end
    check(16'(mult), 16'h0307);
    check(16'(refDiv), 16'd129);
    check(16'({pump, trim}), 16'h03a5);
    wr(8'h47, 8'h10);
    for (int i = 0; i < 8; i++) begin
      code = 3'(i);
      wr(8'h0c, code == 3'h3 ? 8'h06 : 8'h0c);
      wr(8'h44, code[2] ? 8'hfe : 8'hfc);
      wr(8'h45, {~code[2], 3'h7, code, 1'b0});
      repeat (8) @(posedge sys_clk);
      measure(96);
      check(riseA, expA[i]);
      if (code != 3'h0 && code != 3'h7)
        check(co, riseB);
    end
    wr(8'h45, 8'hf2);
    wr(8'h46, 8'hbf);
    wr(8'h0c, 8'h8c);
    repeat (200) @(posedge sys_clk);
    measure(384);
    check(riseA, 16'd2);
    check(riseC, 16'd12);
    wr(8'h09, 8'h24);
    measure(384);
    check(riseA, 16'h0000);
    // Output B still takes bank 2 over two from the reference, rising every second cycle.
    check(riseB, 16'h00c0);
    wrap_up();
  end

  initial begin
    #450000;
    n_errors++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
